// ---- design/fpalu_consts.svh ----
// constants for the fixed-point alu datapath: offsets, field positions, limits
`ifndef FPALU_CONSTS_SVH
`define FPALU_CONSTS_SVH

// ----------------------------------------------------------------------
// register port offsets (byte addresses)
// ----------------------------------------------------------------------
`define FPALU_ADDR_W 4
`define FPALU_OFS_MODE 4'h0
`define FPALU_OFS_ARITH_STATUS_REGISTER 4'h4
`define FPALU_OFS_STICKY_STATUS_REGISTER 4'h8

// ----------------------------------------------------------------------
// operand layout: 32-bit fixed field above an 8-bit extension field
// ----------------------------------------------------------------------
`define FPALU_REG_W 40
`define FPALU_FIX_HI 39
`define FPALU_FIX_LO 8
`define FPALU_EXT_ZERO 8'h00

// ----------------------------------------------------------------------
// mode control register bits
// ----------------------------------------------------------------------
`define FPALU_MODE_SAT 0
`define FPALU_MODE_RND 1

// ----------------------------------------------------------------------
// arith status register bits
// ----------------------------------------------------------------------
`define FPALU_AST_ZERO 0
`define FPALU_AST_OVF 1
`define FPALU_AST_NEG 2
`define FPALU_AST_CARRY 3
`define FPALU_AST_ISIGN 4
`define FPALU_AST_INV 5
`define FPALU_AST_FLT 10
`define FPALU_AST_HIST_HI 31
`define FPALU_AST_HIST_LO 24
`define FPALU_HIST_W 8

// ----------------------------------------------------------------------
// sticky status register bits
// ----------------------------------------------------------------------
`define FPALU_STK_FOVF 0
`define FPALU_STK_UNF 1
`define FPALU_STK_INV 2
`define FPALU_STK_FLTOVF 3

// ----------------------------------------------------------------------
// reset values and saturation limits
// ----------------------------------------------------------------------
`define FPALU_RST_WORD 32'h0000_0000
`define FPALU_SAT_POS 32'h7fff_ffff
`define FPALU_SAT_NEG 32'h8000_0000
`define FPALU_ONES 32'hffff_ffff

`endif

// ---- design/fpalu_pkg.sv ----
// types shared by the fixed-point alu datapath and its users
package fpalu_pkg;

   typedef enum logic [3:0] {
      FPALU_OP_ADD,
      FPALU_OP_SUB,
      FPALU_OP_ADD_CI,
      FPALU_OP_SUB_CI,
      FPALU_OP_AVG,
      FPALU_OP_CMP,
      FPALU_OP_CMPU,
      FPALU_OP_CI_ONLY,
      FPALU_OP_BI_ONLY
   } fpalu_op_t;

   typedef struct packed {
      fpalu_op_t op;
      logic [3:0] dst;
      logic [39:0] src_x;
      logic [39:0] src_y;
   } fpalu_req_t;

   typedef struct packed {
      logic [3:0] dst;
      logic [39:0] data;
   } fpalu_res_t;

endpackage : fpalu_pkg

// ---- design/fpalu_core.sv ----
// fixed-point alu datapath with mode, status and sticky registers
// Operation
// RULE1 - every operation clears the float result flag
// RULE2 - only compares touch compare history
// RULE3 - add writes sum of fixed fields
// RULE4 - result extension field forced to zero
// RULE5 - saturation clamps overflow to max/min
// RULE6 - subtract gives x minus y
// RULE7 - add with carry adds carry flag
// RULE8 - subtract with borrow: x-y+carry-1
// RULE9 - average halves sum, rounds, clears overflow
// RULE10 - carry flag is adder carry out
// RULE11 - overflow is xor of top carries
// RULE12 - negative flag copies result msb
// RULE13 - zero flag on zero result, clear others
// RULE14 - overflow sets sticky overflow, others kept
// RULE15 - signed compare sets zero/negative, clears rest
// RULE16 - unsigned compare by magnitude, same flags
// RULE17 - eight-deep history shifts right per compare
// RULE18 - history msb set when x greater
// RULE19 - carry-only add, positive saturation
// RULE20 - borrow-only add, same saturation and flags
// RULE21 - without saturation results wrap, flags update
`include "fpalu_consts.svh"

module fpalu_core (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic op_valid,
   input wire fpalu_pkg::fpalu_req_t op_req,
   output logic res_valid,
   output fpalu_pkg::fpalu_res_t res,
   input wire logic [`FPALU_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic [31:0] arith_status,
   output logic [31:0] sticky_status
);
   import fpalu_pkg::*;

   // ----------------------------------------------------------------------
   // op decoding shared by flag, history and result logic
   // ----------------------------------------------------------------------
   function automatic logic op_is_cmp(input fpalu_op_t o);
      return (o == FPALU_OP_CMP) || (o == FPALU_OP_CMPU);
   endfunction : op_is_cmp

   function automatic logic op_is_signed_cmp(input fpalu_op_t o);
      return (o == FPALU_OP_CMP);
   endfunction : op_is_signed_cmp

   // average and compares always clear overflow, so never feed the sticky
   function automatic logic op_sets_ovf(input fpalu_op_t o);
      return !op_is_cmp(o) && (o != FPALU_OP_AVG);
   endfunction : op_sets_ovf

   function automatic logic op_is_avg(input fpalu_op_t o);
      return (o == FPALU_OP_AVG);
   endfunction : op_is_avg

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   logic [31:0] mode_q, mode_d;
   logic [31:0] arith_status_register_q, arith_status_register_d;
   logic [31:0] sticky_status_register_q, sticky_status_register_d;
   logic res_valid_q, res_valid_d;
   fpalu_res_t res_q, res_d;
   logic [31:0] rdata_q, rdata_d;

   // ----------------------------------------------------------------------
   // shared adder
   // ----------------------------------------------------------------------
   logic [31:0] fx, fy, add_b, sum, avg, fix_res, sat_res;
   logic [32:0] sum33;
   logic add_cin, cout, c31, ovf, sat_en, rnd_near, carry_in;
   logic is_cmp, cmp_lt, cmp_eq, cmp_gt, pos_only;

   assign fx = op_req.src_x[`FPALU_FIX_HI:`FPALU_FIX_LO];
   assign fy = op_req.src_y[`FPALU_FIX_HI:`FPALU_FIX_LO];
   assign sat_en = mode_q[`FPALU_MODE_SAT];
   assign rnd_near = mode_q[`FPALU_MODE_RND];
   assign carry_in = arith_status_register_q[`FPALU_AST_CARRY];

   // ----------------------------------------------------------------------
   // operand select
   // ----------------------------------------------------------------------
   always_comb begin
      add_b = fy;
      add_cin = 1'b0;
      pos_only = 1'b0;
      unique case (op_req.op)
         FPALU_OP_ADD: begin
            add_b = fy; // [RULE3]
            add_cin = 1'b0;
            pos_only = 1'b0;
         end
         FPALU_OP_SUB: begin
            add_b = ~fy; // [RULE6]
            add_cin = 1'b1;
            pos_only = 1'b0;
         end
         FPALU_OP_ADD_CI: begin
            add_b = fy;
            add_cin = carry_in; // [RULE7]
            pos_only = 1'b0;
         end
         FPALU_OP_SUB_CI: begin
            // x + ~y + 1 + carry - 1
            add_b = ~fy; // [RULE8]
            add_cin = carry_in;
            pos_only = 1'b0;
         end
         FPALU_OP_CI_ONLY: begin
            add_b = `FPALU_RST_WORD; // [RULE19]
            add_cin = carry_in;
            pos_only = 1'b1;
         end
         FPALU_OP_BI_ONLY: begin
            // carry - 1 folded in as all ones plus carry
            add_b = `FPALU_ONES; // [RULE20]
            add_cin = carry_in;
            pos_only = 1'b1;
         end
         FPALU_OP_CMP, FPALU_OP_CMPU, FPALU_OP_AVG: begin
            add_b = fy;
            add_cin = 1'b0;
            pos_only = 1'b0;
         end
         default: begin
            add_b = fy;
            add_cin = 1'b0;
            pos_only = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // adder carry and overflow taps
   // ----------------------------------------------------------------------
   assign sum33 = {1'b0, fx} + {1'b0, add_b} + {32'h0000_0000, add_cin};
   assign sum = sum33[31:0];
   assign cout = sum33[32]; // [RULE10]
   assign c31 = fx[31] ^ add_b[31] ^ sum[31];
   assign ovf = cout ^ c31; // [RULE11]

   // ----------------------------------------------------------------------
   // average
   // ----------------------------------------------------------------------
   // halve the true 33-bit signed sum; a tie rounds to even when nearest
   always_comb begin
      avg = {fx[31] ^ fy[31] ^ cout, sum[31:1]};
      if (rnd_near && sum[0] && sum[1]) begin
         avg = avg + 32'h0000_0001; // [RULE9]
      end
   end

   // ----------------------------------------------------------------------
   // saturation
   // ----------------------------------------------------------------------
   // wrap when saturation is off; clamp by the sign of the wrapped result
   always_comb begin
      sat_res = sum; // [RULE21]
      if (sat_en && ovf) begin
         if (sum[31]) begin
            sat_res = `FPALU_SAT_POS; // [RULE5] [RULE19] [RULE20]
         end else if (!pos_only) begin
            sat_res = `FPALU_SAT_NEG; // [RULE5]
         end
      end
   end

   // ----------------------------------------------------------------------
   // compare
   // ----------------------------------------------------------------------
   assign is_cmp = op_is_cmp(op_req.op);
   assign cmp_eq = (fx == fy);
   always_comb begin
      if (op_is_signed_cmp(op_req.op)) begin
         cmp_lt = ($signed(fx) < $signed(fy)); // [RULE15]
      end else begin
         cmp_lt = (fx < fy); // [RULE16]
      end
   end
   // greater is neither less nor equal, so one comparator serves both
   assign cmp_gt = !cmp_lt && !cmp_eq;
   assign fix_res = op_is_avg(op_req.op) ? avg : sat_res;

   // ----------------------------------------------------------------------
   // compare history shifter
   // ----------------------------------------------------------------------
   logic [`FPALU_HIST_W-1:0] hist_now;
   logic [`FPALU_HIST_W-1:0] hist_shift;
   logic zero_nx;
   logic ovf_nx;
   logic neg_nx;
   logic carry_nx;
   logic fovf_set;

   assign hist_now = arith_status_register_q[`FPALU_AST_HIST_HI:`FPALU_AST_HIST_LO];
   assign hist_shift[`FPALU_HIST_W-1] = cmp_gt; // [RULE18]
   // newest outcome enters at the top, the oldest falls off bit zero
   for (genvar i = 0; i < `FPALU_HIST_W - 1; i++) begin : g_hist
      assign hist_shift[i] = hist_now[i + 1]; // [RULE17]
   end

   // ----------------------------------------------------------------------
   // alu flags
   // ----------------------------------------------------------------------
   always_comb begin
      zero_nx = 1'b0;
      ovf_nx = 1'b0;
      neg_nx = 1'b0;
      carry_nx = 1'b0;
      fovf_set = 1'b0;
      if (is_cmp) begin
         zero_nx = cmp_eq; // [RULE15] [RULE16]
         neg_nx = cmp_lt; // [RULE15] [RULE16]
      end else begin
         zero_nx = (fix_res == `FPALU_RST_WORD); // [RULE13]
         neg_nx = fix_res[31]; // [RULE12]
         // carry is the adder carry out for every arithmetic op, average too
         carry_nx = cout; // [RULE10]
         if (op_sets_ovf(op_req.op)) begin
            ovf_nx = ovf; // [RULE11] [RULE21]
            fovf_set = ovf; // [RULE14]
         end else begin
            ovf_nx = 1'b0; // [RULE9]
         end
      end
   end

   // ----------------------------------------------------------------------
   // mode control register
   // ----------------------------------------------------------------------
   always_comb begin
      mode_d = mode_q;
      if (reg_wr && (reg_addr == `FPALU_OFS_MODE)) begin
         mode_d = reg_wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         mode_q <= `FPALU_RST_WORD;
      end else begin
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------------------------------------
   // arith status register
   // ----------------------------------------------------------------------
   always_comb begin
      arith_status_register_d = arith_status_register_q;
      // software writes first; a same-cycle alu update overrides the flag and history fields
      if (reg_wr && (reg_addr == `FPALU_OFS_ARITH_STATUS_REGISTER)) begin
         arith_status_register_d = reg_wdata;
      end
      if (op_valid) begin
         arith_status_register_d[`FPALU_AST_FLT] = 1'b0; // [RULE1]
         arith_status_register_d[`FPALU_AST_ISIGN] = 1'b0; // [RULE13] [RULE15]
         arith_status_register_d[`FPALU_AST_INV] = 1'b0; // [RULE13] [RULE15]
         arith_status_register_d[`FPALU_AST_ZERO] = zero_nx;
         arith_status_register_d[`FPALU_AST_NEG] = neg_nx;
         arith_status_register_d[`FPALU_AST_CARRY] = carry_nx; // [RULE15]
         arith_status_register_d[`FPALU_AST_OVF] = ovf_nx; // [RULE15]
         // only compares move the history; all else rewrites the held bits
         if (is_cmp) begin
            arith_status_register_d[`FPALU_AST_HIST_HI:`FPALU_AST_HIST_LO] = hist_shift; // [RULE17]
         end else begin
            arith_status_register_d[`FPALU_AST_HIST_HI:`FPALU_AST_HIST_LO] = hist_now; // [RULE2]
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         arith_status_register_q <= `FPALU_RST_WORD;
      end else begin
         arith_status_register_q <= arith_status_register_d;
      end
   end

   // ----------------------------------------------------------------------
   // sticky status register
   // ----------------------------------------------------------------------
   always_comb begin
      sticky_status_register_d = sticky_status_register_q;
      if (reg_wr && (reg_addr == `FPALU_OFS_STICKY_STATUS_REGISTER)) begin
         sticky_status_register_d = reg_wdata;
      end
      // set wins over a same-cycle software clear; float stickies just hold
      if (op_valid && fovf_set) begin
         sticky_status_register_d[`FPALU_STK_FOVF] = 1'b1; // [RULE14]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sticky_status_register_q <= `FPALU_RST_WORD;
      end else begin
         sticky_status_register_q <= sticky_status_register_d;
      end
   end

   // ----------------------------------------------------------------------
   // result port
   // ----------------------------------------------------------------------
   always_comb begin
      res_valid_d = 1'b0;
      res_d = res_q;
      // compares leave the destination untouched, so no result pulse
      if (op_valid && !is_cmp) begin
         res_valid_d = 1'b1;
         res_d.dst = op_req.dst;
         res_d.data = {fix_res, `FPALU_EXT_ZERO}; // [RULE3] [RULE4]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         res_valid_q <= 1'b0;
      end else begin
         res_valid_q <= res_valid_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         res_q <= '0;
      end else begin
         res_q <= res_d;
      end
   end

   // ----------------------------------------------------------------------
   // register read port
   // ----------------------------------------------------------------------
   always_comb begin
      rdata_d = `FPALU_RST_WORD;
      // read data stands for one cycle only; idle and unmapped read zero
      if (reg_rd) begin
         unique case (reg_addr)
            `FPALU_OFS_MODE: rdata_d = mode_q;
            `FPALU_OFS_ARITH_STATUS_REGISTER: rdata_d = arith_status_register_q;
            `FPALU_OFS_STICKY_STATUS_REGISTER: rdata_d = sticky_status_register_q;
            default: rdata_d = `FPALU_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rdata_q <= `FPALU_RST_WORD;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign res_valid = res_valid_q;
   assign res = res_q;
   assign reg_rdata = rdata_q;
   assign arith_status = arith_status_register_q;
   assign sticky_status = sticky_status_register_q;

endmodule : fpalu_core

// ---- dv/fpalu_chk_props.sv ----
// port-level assertion checker for the fixed-point alu datapath
module fpalu_chk
   import fpalu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic op_valid,
   input wire fpalu_pkg::fpalu_req_t op_req,
   input wire logic res_valid,
   input wire fpalu_pkg::fpalu_res_t res,
   input wire logic reg_wr,
   input wire logic [31:0] arith_status,
   input wire logic [31:0] sticky_status
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic cmp = op_valid && (op_req.op inside {FPALU_OP_CMP, FPALU_OP_CMPU});
   wire logic sgt = $signed(op_req.src_x[39:8]) > $signed(op_req.src_y[39:8]);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   float_clear_a: assert property (op_valid && !reg_wr |=> !arith_status[10])
      else $error("float flag left set");
   hist_hold_a: assert property (op_valid && !cmp && !reg_wr |=> $stable(arith_status[31:24]))
      else $error("history moved on non-compare");
   ext_zero_a: assert property (res_valid |-> res.data[7:0] == 8'h00)
      else $error("extension field not zero");
   res_timing_a: assert property (op_valid |=> res_valid != $past(cmp))
      else $error("result pulse wrong");
   zero_flag_a: assert property (res_valid |-> arith_status[0] == (res.data[39:8] == 32'h0)
      && !arith_status[4] && !arith_status[5])
      else $error("zero or cleared flags wrong");
   sticky_ovf_a: assert property (res_valid && arith_status[1] |-> sticky_status[0])
      else $error("sticky overflow not set");
   avg_ovf_a: assert property (op_valid && op_req.op == FPALU_OP_AVG |=> !arith_status[1])
      else $error("average left overflow set");
   hist_shift_a: assert property (cmp && !reg_wr |=>
      arith_status[30:24] == $past(arith_status[31:25]))
      else $error("history not shifted");
   hist_msb_a: assert property (cmp && op_req.op == FPALU_OP_CMP |=>
      arith_status[31] == $past(sgt) && !arith_status[3] && !arith_status[1])
      else $error("compare history bit wrong");
   cover property (cmp);
   cover property (res_valid && arith_status[1]);
   cover property (op_valid && op_req.op == FPALU_OP_AVG);
endmodule : fpalu_chk

bind fpalu_core fpalu_chk u_chk (.ref_clk, .srst, .op_valid, .op_req, .res_valid, .res,
   .reg_wr, .arith_status, .sticky_status);

// ---- dv/fpalu_rf_model.sv ----
// register file model that takes alu results back
module fpalu_rf_model
   import fpalu_pkg::*;
(
   input wire logic ref_clk,
   input wire logic res_valid,
   input wire fpalu_pkg::fpalu_res_t res
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [39:0] rf [16];
   always_ff @(posedge ref_clk) begin
      if (res_valid) begin
         rf[res.dst] <= res.data;
      end
   end
endmodule : fpalu_rf_model

// ---- dv/fixed_point_alu_ops_tb_top.sv ----
// self-checking bench for the fixed-point alu datapath
module fixed_point_alu_ops_tb_top;
   import fpalu_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] all_m = 32'hffff_ffff;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic op_valid = 1'b0;
   fpalu_req_t op_req = '0;
   logic res_valid;
   fpalu_res_t res;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, arith_status, sticky_status;
   int failures = 0;
   int compares = 0;
   int cycles = 0;
   always #2 ref_clk = ~ref_clk;
   fpalu_core DUT (.ref_clk, .srst, .op_valid, .op_req, .res_valid, .res, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .arith_status, .sticky_status);
   fpalu_rf_model u_rf (.ref_clk, .res_valid, .res);
   task automatic close_out();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out
   task automatic chk(logic [39:0] got, logic [39:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   // nonzero extension bits on the sources must never leak into the result
   task automatic op(fpalu_op_t o, logic [31:0] x, y, d, a, m);
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_req <= '{o, 4'h1, {x, 8'hff}, {y, 8'h5a}};
      @(posedge ref_clk);
      op_valid <= 1'b0;
      #1;
      chk(res_valid, !(o inside {FPALU_OP_CMP, FPALU_OP_CMPU}));
      if (res_valid === 1'b1) chk(res.data, {d, 8'h00});
      if (res_valid === 1'b1) chk(res.dst, 4'h1);
      chk(arith_status & m, a & m);
   endtask : op
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      rd(4'h0, 32'h0);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h0);
      wr(4'hc, all_m);
      rd(4'hc, 32'h0);
      wr(4'h4, 32'h0000_0400);
      op(FPALU_OP_ADD, 32'h1, 32'h2, 32'h3, 32'h0, all_m);
      op(FPALU_OP_ADD, 32'h7fff_ffff, 32'h1, 32'h8000_0000, 32'h6, all_m);
      chk(sticky_status, 32'h1);
      op(FPALU_OP_SUB, 32'h5, 32'h5, 32'h0, 32'h9, all_m);
      op(FPALU_OP_ADD_CI, 32'h1, 32'h2, 32'h4, 32'h0, all_m);
      op(FPALU_OP_SUB_CI, 32'h5, 32'h3, 32'h1, 32'h8, all_m);
      wr(4'h0, 32'h1);
      op(FPALU_OP_ADD, 32'h7fff_ffff, 32'h1, 32'h7fff_ffff, 32'h2, 32'h2);
      op(FPALU_OP_SUB, 32'h8000_0000, 32'h1, 32'h8000_0000, 32'h2, 32'h2);
      op(FPALU_OP_ADD, all_m, 32'h1, 32'h0, 32'h9, all_m);
      op(FPALU_OP_CI_ONLY, 32'h7fff_ffff, 32'h0, 32'h7fff_ffff, 32'h2, 32'h2);
      op(FPALU_OP_BI_ONLY, 32'h5, 32'h0, 32'h4, 32'h0, 32'h7);
      wr(4'h0, 32'h0);
      op(FPALU_OP_AVG, 32'h3, 32'h4, 32'h3, 32'h0, all_m);
      wr(4'h0, 32'h2);
      op(FPALU_OP_AVG, 32'h3, 32'h4, 32'h4, 32'h0, all_m);
      op(FPALU_OP_AVG, 32'h2, 32'h3, 32'h2, 32'h0, all_m);
      op(FPALU_OP_CMP, all_m, 32'h1, 32'h0, 32'h4, all_m);
      op(FPALU_OP_CMP, 32'h2, 32'h1, 32'h0, 32'h8000_0000, all_m);
      op(FPALU_OP_CMPU, all_m, 32'h1, 32'h0, 32'hc000_0000, all_m);
      op(FPALU_OP_CMPU, 32'h1, 32'h1, 32'h0, 32'h6000_0001, all_m);
      op(FPALU_OP_ADD, 32'h0, 32'h0, 32'h0, 32'h6000_0001, all_m);
      rd(4'h8, 32'h1);
      wr(4'h8, 32'h0);
      rd(4'h8, 32'h0);
      close_out();
   end
endmodule : fixed_point_alu_ops_tb_top
